// ===== include/ppcb_defs.vh
// constants and register map of the port pin control bank
`ifndef PPCB_DEFS_VH
`define PPCB_DEFS_VH

// ----------------------------------------
// window bases
// ----------------------------------------
`define PPCB_PORTL_BASE 24'h400C0B
`define PPCB_PORTM_BASE 24'h400C0C
`define PPCB_PORTN_BASE 24'h400C0D

// ----------------------------------------
// offsets inside a window
// ----------------------------------------
`define PPCB_OFS_DATA 8'h00
`define PPCB_OFS_OUTEN 8'h04
`define PPCB_OFS_FUNC1 8'h08
`define PPCB_OFS_FUNC2 8'h0C
`define PPCB_OFS_FUNC6 8'h1C
`define PPCB_OFS_ODRAIN 8'h28
`define PPCB_OFS_PULLUP 8'h2C
`define PPCB_OFS_PULLDN 8'h30
`define PPCB_OFS_INEN 8'h38

// ----------------------------------------
// field positions and reset value
// ----------------------------------------
`define PPCB_PORTL_CTS_BIT 3
`define PPCB_PORTN_F1_LSB 2
`define PPCB_PORTN_F2_LSB 4
`define PPCB_RESET_VAL 32'h00000000

`endif

// ===== src/ppcb_pin_bank.v
// pin control bank for ports M and N and the pad tail of port L
`timescale 1ns/1ps
`include "ppcb_defs.vh"

module ppcb_pin_bank #(
    parameter PM_PINS = 4,
    parameter PN_PINS = 6,
    parameter PL_PINS = 8
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // register port
    input wire [31:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regRdData_q,
    // port M pads
    input wire [PM_PINS-1:0] portmPinIn,
    output wire [PM_PINS-1:0] portmPinOut,
    output wire [PM_PINS-1:0] portmPinOe,
    output reg [PM_PINS-1:0] portmPullUp_q,
    output reg [PM_PINS-1:0] portmPullDown_q,
    // port N pads
    input wire [PN_PINS-1:0] portnPinIn,
    output wire [PN_PINS-1:0] portnPinOut,
    output wire [PN_PINS-1:0] portnPinOe,
    output reg [PN_PINS-1:0] portnPullUp_q,
    output reg [PN_PINS-1:0] portnPullDown_q,
    // port L pad controls
    input wire portlPin3In,
    output reg [PL_PINS-1:0] portlOpenDrain_q,
    output reg [PL_PINS-1:0] portlPullUp_q,
    output reg [PL_PINS-1:0] portlPullDown_q,
    output reg [PL_PINS-1:0] portlInEnable_q,
    // ethernet media interface side
    input wire ethMgmtDataOut,
    input wire ethMgmtDataOe,
    output reg ethMgmtDataIn_q,
    input wire ethMgmtClockLine,
    output reg ethCollisionIn_q,
    input wire ethTransmitData2,
    input wire ethTransmitData3,
    input wire ethTransmitEnable,
    output reg ethTransmitClock_q,
    // encoder, converter, timer and serial side
    output reg encoderPhaseAIn_q,
    output reg encoderPhaseBIn_q,
    output reg encoderIndexIn_q,
    output reg converterBTriggerIn_q,
    output reg [1:0] timerCaptureIn_q,
    output reg serial2ClearToSend_q
);

    localparam NPINS = PM_PINS + PN_PINS;

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    reg [PM_PINS-1:0] portm_pin_data_q;
    reg [PM_PINS-1:0] pmOutEn_q;
    reg [2:0] pmFunc1_q;
    reg [3:0] pmFunc2_q;
    reg [PM_PINS-1:0] pmOpenDrain_q;
    reg [PM_PINS-1:0] pmInEn_q;
    reg [PN_PINS-1:0] portn_pin_data_q;
    reg [PN_PINS-1:0] pnOutEn_q;
    reg [3:0] pnFunc1_q;
    reg [1:0] pnFunc2_q;
    reg [PN_PINS-1:0] pnOpenDrain_q;
    reg [PN_PINS-1:0] pnInEn_q;
    reg plFunc6_q;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // the full address is compared, so no window aliases into another
    wire [7:0] ofs = regAddr[7:0];
    wire selM = (regAddr[31:8] == `PPCB_PORTM_BASE);
    wire selN = (regAddr[31:8] == `PPCB_PORTN_BASE);
    wire selL = (regAddr[31:8] == `PPCB_PORTL_BASE);
    wire wrM = regWrite & selM;
    wire wrN = regWrite & selN;
    wire wrL = regWrite & selL;

    // reserved offsets fall to the default item and unmapped windows skip the case, so a stray
    // access stores nothing and reads zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portm_pin_data_q <= {PM_PINS{1'b0}};
            pmOutEn_q <= {PM_PINS{1'b0}};
            pmFunc1_q <= 3'h0;
            pmFunc2_q <= 4'h0;
            pmOpenDrain_q <= {PM_PINS{1'b0}};
            portmPullUp_q <= {PM_PINS{1'b0}};
            portmPullDown_q <= {PM_PINS{1'b0}};
            pmInEn_q <= {PM_PINS{1'b0}};
        end else if (wrM) begin
            case (ofs)
                `PPCB_OFS_DATA: portm_pin_data_q <= regWrData[PM_PINS-1:0];
                `PPCB_OFS_OUTEN: pmOutEn_q <= regWrData[PM_PINS-1:0];
                `PPCB_OFS_FUNC1: pmFunc1_q <= regWrData[2:0];
                `PPCB_OFS_FUNC2: pmFunc2_q <= regWrData[3:0];
                `PPCB_OFS_ODRAIN: pmOpenDrain_q <= regWrData[PM_PINS-1:0];
                `PPCB_OFS_PULLUP: portmPullUp_q <= regWrData[PM_PINS-1:0];
                `PPCB_OFS_PULLDN: portmPullDown_q <= regWrData[PM_PINS-1:0];
                `PPCB_OFS_INEN: pmInEn_q <= regWrData[PM_PINS-1:0];
                default: portm_pin_data_q <= portm_pin_data_q;
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portn_pin_data_q <= {PN_PINS{1'b0}};
            pnOutEn_q <= {PN_PINS{1'b0}};
            pnFunc1_q <= 4'h0;
            pnFunc2_q <= 2'h0;
            pnOpenDrain_q <= {PN_PINS{1'b0}};
            portnPullUp_q <= {PN_PINS{1'b0}};
            portnPullDown_q <= {PN_PINS{1'b0}};
            pnInEn_q <= {PN_PINS{1'b0}};
        end else if (wrN) begin
            case (ofs)
                `PPCB_OFS_DATA: portn_pin_data_q <= regWrData[PN_PINS-1:0];
                `PPCB_OFS_OUTEN: pnOutEn_q <= regWrData[PN_PINS-1:0];
                `PPCB_OFS_FUNC1: pnFunc1_q <= regWrData[5:2];
                `PPCB_OFS_FUNC2: pnFunc2_q <= regWrData[5:4];
                `PPCB_OFS_ODRAIN: pnOpenDrain_q <= regWrData[PN_PINS-1:0];
                `PPCB_OFS_PULLUP: portnPullUp_q <= regWrData[PN_PINS-1:0];
                `PPCB_OFS_PULLDN: portnPullDown_q <= regWrData[PN_PINS-1:0];
                `PPCB_OFS_INEN: pnInEn_q <= regWrData[PN_PINS-1:0];
                default: portn_pin_data_q <= portn_pin_data_q;
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            plFunc6_q <= 1'b0;
            portlOpenDrain_q <= {PL_PINS{1'b0}};
            portlPullUp_q <= {PL_PINS{1'b0}};
            portlPullDown_q <= {PL_PINS{1'b0}};
            portlInEnable_q <= {PL_PINS{1'b0}};
        end else if (wrL) begin
            case (ofs)
                `PPCB_OFS_FUNC6: plFunc6_q <= regWrData[`PPCB_PORTL_CTS_BIT];
                `PPCB_OFS_ODRAIN: portlOpenDrain_q <= regWrData[PL_PINS-1:0];
                `PPCB_OFS_PULLUP: portlPullUp_q <= regWrData[PL_PINS-1:0];
                `PPCB_OFS_PULLDN: portlPullDown_q <= regWrData[PL_PINS-1:0];
                `PPCB_OFS_INEN: portlInEnable_q <= regWrData[PL_PINS-1:0];
                default: plFunc6_q <= plFunc6_q;
            endcase
        end
    end

    // ----------------------------------------
    // combined pin view, port M in the low bits
    // ----------------------------------------
    wire [NPINS-1:0] allData = {portn_pin_data_q, portm_pin_data_q};
    wire [NPINS-1:0] allOutEn = {pnOutEn_q, pmOutEn_q};
    wire [NPINS-1:0] allOpenDrain = {pnOpenDrain_q, pmOpenDrain_q};
    wire [NPINS-1:0] allInEn = {pnInEn_q, pmInEn_q};
    wire [NPINS-1:0] allPinIn = {portnPinIn, portmPinIn};

    // only output functions take over the pin level; input functions leave
    // the data register on the driver, so a stray output enable drives that latch onto the input pin
    wire [NPINS-1:0] altSel = {1'b0, pnFunc1_q[2:0], 2'b00, 2'b00,
        pmFunc1_q[1:0]};
    wire [NPINS-1:0] altVal = {1'b0, ethTransmitEnable, ethTransmitData3,
        ethTransmitData2, 2'b00, 2'b00, ethMgmtClockLine, ethMgmtDataOut};
    // the management data line is turned round by the media interface
    wire [NPINS-1:0] altOeOk = {{(NPINS-1){1'b1}}, ~pmFunc1_q[0] | ethMgmtDataOe};

    wire [NPINS-1:0] pinSeen;
    reg [NPINS-1:0] syncA_q;
    reg [NPINS-1:0] syncB_q;
    reg [NPINS-1:0] padOut_q;
    reg [NPINS-1:0] padOe_q;

    // ----------------------------------------
    // per-pin pad logic
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < NPINS; i = i + 1) begin : gPin
            wire level = altSel[i] ? altVal[i] : allData[i];
            wire drive = allOutEn[i] & altOeOk[i];
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    syncA_q[i] <= 1'b0;
                    syncB_q[i] <= 1'b0;
                    padOut_q[i] <= 1'b0;
                    padOe_q[i] <= 1'b0;
                end else begin
                    syncA_q[i] <= allPinIn[i];
                    syncB_q[i] <= syncA_q[i];
                    // open-drain drives only a low, releases for a high
                    padOut_q[i] <= allOpenDrain[i] ? 1'b0 : level;
                    padOe_q[i] <= drive & (allOpenDrain[i] ? ~level : 1'b1);
                end
            end
            assign pinSeen[i] = allInEn[i] & syncB_q[i];
        end
    endgenerate

    assign portmPinOut = padOut_q[PM_PINS-1:0];
    assign portmPinOe = padOe_q[PM_PINS-1:0];
    assign portnPinOut = padOut_q[NPINS-1:PM_PINS];
    assign portnPinOe = padOe_q[NPINS-1:PM_PINS];

    // ----------------------------------------
    // port L pin 3 synchroniser
    // ----------------------------------------
    reg plSyncA_q;
    reg plSyncB_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            plSyncA_q <= 1'b0;
            plSyncB_q <= 1'b0;
        end else begin
            plSyncA_q <= portlPin3In;
            plSyncB_q <= plSyncA_q;
        end
    end

    // ----------------------------------------
    // peripheral inputs
    // ----------------------------------------
    // a blocked input path hands the peripheral a steady low
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ethMgmtDataIn_q <= 1'b0;
            ethCollisionIn_q <= 1'b0;
            encoderPhaseAIn_q <= 1'b0;
            encoderPhaseBIn_q <= 1'b0;
            encoderIndexIn_q <= 1'b0;
            converterBTriggerIn_q <= 1'b0;
            ethTransmitClock_q <= 1'b0;
            timerCaptureIn_q <= 2'h0;
            serial2ClearToSend_q <= 1'b0;
        end else begin
            ethMgmtDataIn_q <= pmFunc1_q[0] & pinSeen[0];
            ethCollisionIn_q <= pmFunc1_q[2] & pinSeen[2];
            encoderPhaseAIn_q <= pmFunc2_q[0] & pinSeen[0];
            encoderPhaseBIn_q <= pmFunc2_q[1] & pinSeen[1];
            encoderIndexIn_q <= pmFunc2_q[2] & pinSeen[2];
            converterBTriggerIn_q <= pmFunc2_q[3] & pinSeen[3];
            ethTransmitClock_q <= pnFunc1_q[3] & pinSeen[PM_PINS+5];
            timerCaptureIn_q <= pnFunc2_q & pinSeen[PM_PINS+5:PM_PINS+4];
            serial2ClearToSend_q <= plFunc6_q & portlInEnable_q[`PPCB_PORTL_CTS_BIT]
                & plSyncB_q;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // data reads return the latch on driven pins, else the gated pin level
    wire [PM_PINS-1:0] pmDataRd = (pmOutEn_q & portm_pin_data_q)
        | (~pmOutEn_q & pinSeen[PM_PINS-1:0]);
    wire [PN_PINS-1:0] pnDataRd = (pnOutEn_q & portn_pin_data_q)
        | (~pnOutEn_q & pinSeen[NPINS-1:PM_PINS]);
    reg [31:0] rdMux;

    always @* begin
        rdMux = `PPCB_RESET_VAL;
        if (selM) begin
            case (ofs)
                `PPCB_OFS_DATA: rdMux[PM_PINS-1:0] = pmDataRd;
                `PPCB_OFS_OUTEN: rdMux[PM_PINS-1:0] = pmOutEn_q;
                `PPCB_OFS_FUNC1: rdMux[2:0] = pmFunc1_q;
                `PPCB_OFS_FUNC2: rdMux[3:0] = pmFunc2_q;
                `PPCB_OFS_ODRAIN: rdMux[PM_PINS-1:0] = pmOpenDrain_q;
                `PPCB_OFS_PULLUP: rdMux[PM_PINS-1:0] = portmPullUp_q;
                `PPCB_OFS_PULLDN: rdMux[PM_PINS-1:0] = portmPullDown_q;
                `PPCB_OFS_INEN: rdMux[PM_PINS-1:0] = pmInEn_q;
                default: rdMux = `PPCB_RESET_VAL;
            endcase
        end else if (selN) begin
            case (ofs)
                `PPCB_OFS_DATA: rdMux[PN_PINS-1:0] = pnDataRd;
                `PPCB_OFS_OUTEN: rdMux[PN_PINS-1:0] = pnOutEn_q;
                `PPCB_OFS_FUNC1: rdMux[5:2] = pnFunc1_q;
                `PPCB_OFS_FUNC2: rdMux[5:4] = pnFunc2_q;
                `PPCB_OFS_ODRAIN: rdMux[PN_PINS-1:0] = pnOpenDrain_q;
                `PPCB_OFS_PULLUP: rdMux[PN_PINS-1:0] = portnPullUp_q;
                `PPCB_OFS_PULLDN: rdMux[PN_PINS-1:0] = portnPullDown_q;
                `PPCB_OFS_INEN: rdMux[PN_PINS-1:0] = pnInEn_q;
                default: rdMux = `PPCB_RESET_VAL;
            endcase
        end else if (selL) begin
            case (ofs)
                `PPCB_OFS_FUNC6: rdMux[`PPCB_PORTL_CTS_BIT] = plFunc6_q;
                `PPCB_OFS_ODRAIN: rdMux[PL_PINS-1:0] = portlOpenDrain_q;
                `PPCB_OFS_PULLUP: rdMux[PL_PINS-1:0] = portlPullUp_q;
                `PPCB_OFS_PULLDN: rdMux[PL_PINS-1:0] = portlPullDown_q;
                `PPCB_OFS_INEN: rdMux[PL_PINS-1:0] = portlInEnable_q;
                default: rdMux = `PPCB_RESET_VAL;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData_q <= `PPCB_RESET_VAL;
        end else if (regRead) begin
            regRdData_q <= rdMux;
        end else begin
            regRdData_q <= `PPCB_RESET_VAL;
        end
    end

endmodule // ppcb_pin_bank

// ===== bench/ppcb_pad_model.sv
// pin level model standing outside ports M and N
`timescale 1ns/1ps
module ppcb_pad_model (
    // clock
    input wire clk,
    // pad controls, port N in bits 9..4, port M in bits 3..0
    input wire [9:0] padOut,
    input wire [9:0] padOe,
    input wire [9:0] padPu,
    input wire [9:0] padPd,
    // external drivers set by the bench
    input wire [9:0] extEn,
    input wire [9:0] extVal,
    // resolved pin levels
    output wire [9:0] padIn
);
    reg [9:0] floatQ = 10'h000;

    // an undriven pin with no pull wanders, so a stale level is never kept
    always @(posedge clk) begin
        floatQ <= ~floatQ;
    end

    assign padIn = (padOe & padOut) | (~padOe & extEn & extVal)
        | (~padOe & ~extEn & padPu)
        | (~padOe & ~extEn & ~padPu & ~padPd & floatQ);
endmodule // ppcb_pad_model

// ===== bench/ppcb_pin_bank_sva.sv
// assertion checker for the port pin control bank
`timescale 1ns/1ps
module ppcb_pin_bank_sva #(
    parameter PM_PINS = 4,
    parameter PN_PINS = 6,
    parameter PL_PINS = 8
) (
    // clock, reset and register port
    input wire clk,
    input wire rst_n,
    input wire [31:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [31:0] regRdData_q,
    // pad side
    input wire [PM_PINS-1:0] portmPinOe,
    input wire [PM_PINS-1:0] portmPullUp_q,
    input wire [PN_PINS-1:0] portnPinOut,
    input wire [PN_PINS-1:0] portnPullDown_q,
    input wire [PL_PINS-1:0] portlOpenDrain_q,
    input wire [PL_PINS-1:0] portlInEnable_q,
    input wire serial2ClearToSend_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_unmapped_read;
        regRead && regAddr[31:8] != 24'h400C0B && regAddr[31:8] != 24'h400C0C
            && regAddr[31:8] != 24'h400C0D |=> regRdData_q == 32'h00000000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
    property p_pm_pullup;
        regWrite && regAddr == 32'h400C0C2C |=> portmPullUp_q == $past(regWrData[PM_PINS-1:0]);
    endproperty
    a_pm_pullup: assert property (p_pm_pullup) else $error("pull-up write lost");
    property p_pn_pulldn;
        regWrite && regAddr == 32'h400C0D30 |=> portnPullDown_q == $past(regWrData[PN_PINS-1:0]);
    endproperty
    a_pn_pulldn: assert property (p_pn_pulldn) else $error("pull-down write lost");
    property p_pl_odrain;
        regWrite && regAddr == 32'h400C0B28 |=> portlOpenDrain_q == $past(regWrData[7:0]);
    endproperty
    a_pl_odrain: assert property (p_pl_odrain) else $error("open-drain write lost");
    property p_pm_oe_off;
        regWrite && regAddr == 32'h400C0C04 && regWrData[3:0] == 4'h0 |=> ##1 portmPinOe == 0;
    endproperty
    a_pm_oe_off: assert property (p_pm_oe_off) else $error("driver left on");
    property p_pn_odrain;
        regWrite && regAddr == 32'h400C0D28 && regWrData[5:0] == 6'h3F |=> ##1 portnPinOut == 0;
    endproperty
    a_pn_odrain: assert property (p_pn_odrain) else $error("open-drain pin driven high");
    property p_cts_blocked;
        !$past(portlInEnable_q[3]) && !$past(portlInEnable_q[3], 2) |-> !serial2ClearToSend_q;
    endproperty
    a_cts_blocked: assert property (p_cts_blocked) else $error("blocked input seen");
    property p_pm_upper;
        regRead && regAddr == 32'h400C0C00 |=> regRdData_q[31:4] == 28'h0000000;
    endproperty
    a_pm_upper: assert property (p_pm_upper) else $error("port M upper bits set");
    property p_pn_upper;
        regRead && regAddr == 32'h400C0D00 |=> regRdData_q[31:6] == 26'h0000000;
    endproperty
    a_pn_upper: assert property (p_pn_upper) else $error("port N upper bits set");
endmodule // ppcb_pin_bank_sva

bind ppcb_pin_bank ppcb_pin_bank_sva #(.PM_PINS(PM_PINS), .PN_PINS(PN_PINS), .PL_PINS(PL_PINS))
    i_ppcb_pin_bank_sva (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData_q(regRdData_q),
    .portmPinOe(portmPinOe), .portmPullUp_q(portmPullUp_q), .portnPinOut(portnPinOut),
    .portnPullDown_q(portnPullDown_q), .portlOpenDrain_q(portlOpenDrain_q),
    .portlInEnable_q(portlInEnable_q), .serial2ClearToSend_q(serial2ClearToSend_q));

// ===== bench/ppcb_pin_bank_test.sv
// self-checking bench for the port pin control bank
`timescale 1ns/1ps
module ppcb_pin_bank_test;
    localparam [31:0] BM = 32'h400C0C00;
    localparam [31:0] BN = 32'h400C0D00;
    localparam [31:0] BL = 32'h400C0B00;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [31:0] regAddr = 32'h00000000;
    reg [31:0] regWrData = 32'h00000000;
    reg regWrite = 1'b0;
    reg regRead = 1'b0;
    reg [9:0] extEn = 10'h000;
    reg [9:0] extVal = 10'h000;
    reg portlPin3In = 1'b0;
    reg [5:0] mac = 6'h02; // txen, tx3, tx2, mgmt clock, mgmt oe, mgmt data
    wire [31:0] regRdData_q;
    wire [3:0] pmOut, pmOe, pmPu, pmPd;
    wire [5:0] pnOut, pnOe, pnPu, pnPd;
    wire [7:0] portl_open_drain_select, plPu, plPd, portl_input_enable;
    wire [9:0] padIn;
    wire [7:0] sideQ; // cts, trigger, index, enc b, enc a, tx clock, collision, mgmt in
    wire [1:0] tcap;
    integer err_total = 0;
    integer check_count = 0;
    integer cycles = 0;

    ppcb_pin_bank i_ppcb_pin_bank (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData_q(regRdData_q),
        .portmPinIn(padIn[3:0]), .portmPinOut(pmOut), .portmPinOe(pmOe), .portmPullUp_q(pmPu),
        .portmPullDown_q(pmPd), .portnPinIn(padIn[9:4]), .portnPinOut(pnOut), .portnPinOe(pnOe),
        .portnPullUp_q(pnPu), .portnPullDown_q(pnPd), .portlPin3In(portlPin3In),
        .portlOpenDrain_q(portl_open_drain_select), .portlPullUp_q(plPu), .portlPullDown_q(plPd),
        .portlInEnable_q(portl_input_enable), .ethMgmtDataOut(mac[0]), .ethMgmtDataOe(mac[1]),
        .ethMgmtDataIn_q(sideQ[0]), .ethMgmtClockLine(mac[2]), .ethCollisionIn_q(sideQ[1]),
        .ethTransmitData2(mac[3]), .ethTransmitData3(mac[4]), .ethTransmitEnable(mac[5]),
        .ethTransmitClock_q(sideQ[2]), .encoderPhaseAIn_q(sideQ[3]), .encoderPhaseBIn_q(sideQ[4]),
        .encoderIndexIn_q(sideQ[5]), .converterBTriggerIn_q(sideQ[6]), .timerCaptureIn_q(tcap),
        .serial2ClearToSend_q(sideQ[7]));
    ppcb_pad_model i_ppcb_pad_model (.clk(clk), .padOut({pnOut, pmOut}), .padOe({pnOe, pmOe}),
        .padPu({pnPu, pmPu}), .padPd({pnPd, pmPd}), .extEn(extEn), .extVal(extVal), .padIn(padIn));

    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            report_and_stop;
        end
    end

    task report_and_stop;
        begin
            if (err_total == 0 && check_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        begin
            @(posedge clk);
            regWrite <= 1'b1;
            regAddr <= a;
            regWrData <= d;
            @(posedge clk);
            regWrite <= 1'b0;
        end
    endtask
    task rdc(input [31:0] a, input [31:0] exp);
        begin
            @(posedge clk);
            regRead <= 1'b1;
            regAddr <= a;
            @(posedge clk);
            regRead <= 1'b0;
            #1 chk(regRdData_q, exp);
        end
    endtask
    // pads lag a write by one edge and pins by three, so five is safe
    task settle;
        begin
            repeat (5) @(posedge clk);
            #1;
        end
    endtask
    function [31:0] adr(input integer p, input integer i);
        reg [31:0] o;
        begin
            o = (i < 4) ? 4 * i : 32'h28 + 4 * (i - 4) + ((i == 7) ? 4 : 0);
            adr = (p == 0) ? BM + o : (p == 1) ? BN + o : (i == 3) ? BL + 32'h1C : BL + o;
        end
    endfunction
    function [31:0] msk(input integer p, input integer i);
        case (p)
            0: msk = (i == 2) ? 32'h07 : 32'h0F;
            1: msk = (i == 2) ? 32'h3C : (i == 3) ? 32'h30 : 32'h3F;
            default: msk = (i == 3) ? 32'h08 : 32'hFF;
        endcase
    endfunction
    task sweep(input doRead, input [31:0] d);
        integer p, i;
        for (p = 0; p < 3; p = p + 1) begin
            for (i = 0; i < 8; i = i + 1) begin
                if (p < 2 || i > 2) begin
                    if (doRead)
                        rdc(adr(p, i), msk(p, i) & d);
                    else
                        wr(adr(p, i), d);
                end
            end
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        begin
            chk({pmOe, pnOe, portl_input_enable}, 32'h0);
            sweep(1'b1, 32'h00000000);
            sweep(1'b0, 32'hFFFFFFFF);
            wr(32'h400C0E38, 32'h00000000);
            rdc(BM + 32'h38, 32'h0F);
            wr(32'h400D0D00, 32'h00000000);
            rdc(BN, 32'h3F);
            rdc(32'h400C0E38, 32'h0);
            sweep(1'b1, 32'hFFFFFFFF);
            chk({pmPu, pnPd, portl_open_drain_select, portl_input_enable}, 32'h3FFFFFF);
            chk({pmPd, pnPu, plPu, plPd}, 32'h3FFFFFF);
            sweep(1'b0, 32'h00000000);
            sweep(1'b1, 32'h00000000);
        end
    endtask
    task t_drive;
        begin
            wr(BM, 32'h0A);
            wr(BM + 32'h04, 32'h0F);
            settle;
            chk({pmOut, pmOe}, 8'hAF);
            wr(BM + 32'h28, 32'h0F);
            settle;
            chk({pmOut, pmOe}, 8'h05);
            wr(BM + 32'h28, 32'h00);
            mac <= 6'h05;
            wr(BM + 32'h08, 32'h03);
            settle;
            chk({pmOut, pmOe}, 8'hBE);
            wr(BM + 32'h08, 32'h00);
            mac <= 6'h2A;
            wr(BM + 32'h04, 32'h00);
            settle;
            chk(pmOe, 4'h0);
            wr(BN + 32'h04, 32'h3F);
            wr(BN + 32'h08, 32'h3C);
            settle;
            chk({pnOut, pnOe}, 12'h53F);
        end
    endtask
    task t_input;
        begin
            wr(BN + 32'h04, 32'h00);
            wr(BN + 32'h08, 32'h00);
            extEn <= 10'h3F0;
            extVal <= 10'h2D0;
            settle;
            rdc(BN, 32'h0);
            wr(BN + 32'h38, 32'h3F);
            settle;
            rdc(BN, 32'h2D);
            wr(BN + 32'h2C, 32'h3F);
            extEn <= 10'h000;
            settle;
            rdc(BN, 32'h3F);
            wr(BN + 32'h0C, 32'h30);
            wr(BN + 32'h08, 32'h20);
            settle;
            chk({sideQ[2], tcap}, 3'h7);
            wr(BN + 32'h2C, 32'h00);
            wr(BN + 32'h30, 32'h3F);
            settle;
            rdc(BN, 32'h0);
            chk({sideQ[2], tcap}, 3'h0);
        end
    endtask
    task t_periph;
        begin
            wr(BM + 32'h0C, 32'h0F);
            extEn <= 10'h00F;
            extVal <= 10'h005;
            wr(BM + 32'h38, 32'h0F);
            settle;
            chk(sideQ[6:3], 4'h5);
            wr(BM + 32'h38, 32'h00);
            settle;
            chk(sideQ[6:3], 4'h0);
            wr(BM + 32'h0C, 32'h00);
            extVal <= 10'h005;
            wr(BM + 32'h08, 32'h05);
            wr(BM + 32'h38, 32'h0F);
            settle;
            chk(sideQ[1:0], 2'h3);
            wr(BL + 32'h1C, 32'h08);
            portlPin3In <= 1'b1;
            wr(BL + 32'h38, 32'h08);
            settle;
            chk(sideQ[7], 1'b1);
            wr(BL + 32'h38, 32'h00);
            settle;
            chk(sideQ[7], 1'b0);
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_drive;
        t_input;
        t_periph;
        report_and_stop;
    end
endmodule // ppcb_pin_bank_test
